// File: dv/sdso_master_model.sv
// Fieldbus master model: one object access at a time over the request port.
// Assumes the bank answers each request with a registered ack within four cycles.
`timescale 1ns/1ps
module sdso_master_model (
    input wire logic i_clk_sys,
    input wire logic i_ack,
    input wire logic i_abort,
    input wire logic [15:0] i_rdata,
    output sdso_pkg::sdso_obj_req_s o_obj
);
    import sdso_pkg::*;
    initial o_obj = '0;
    // One-cycle request; released fields carry inverted values, never the stale ones
    task automatic access(input logic w, input logic [15:0] i, input logic [15:0] d,
                          output logic [15:0] r, output logic a);
        @(negedge i_clk_sys);
        o_obj = '{1'b1, w, i, d};
        @(negedge i_clk_sys);
        o_obj = '{1'b0, ~w, ~i, ~d};
        repeat (4) if (!i_ack) @(negedge i_clk_sys);
        r = i_rdata;
        // A missing answer leaves the refusal flag unknown, so the refusal check fails
        a = i_ack ? i_abort : 1'bx;
    endtask
endmodule

// File: dv/stepper_drive_status_objects_test.sv
// Bench for the object bank: table of accesses, then faults and position.
// Assumes the master model above; a 4-bit count makes saturation quick.
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("unexpected %0t: %h not %h", $time, g, e); end end
module stepper_drive_status_objects_test;
    import sdso_pkg::*;
    typedef struct {logic w; logic [15:0] i; logic [15:0] d; logic [15:0] r; logic a;} sdso_row_s;
    logic clk = 0, rst_n = 0, step = 0, dir = 1, en = 1, ack, ab, mdir, fa;
    sdso_drive_s drv = 5'b10001;
    logic signed [15:0] spd = 16'sd4000;
    logic [15:0] vb = 16'h1234;
    logic [5:0] pins = 6'h2a;
    logic [1:0] oact = 2'b01;
    sdso_fault_s flt = '0;
    logic [15:0] rd, amp, pa, pb;
    logic signed [3:0] pos;
    sdso_loop_mode_e mode, mode_cl;
    sdso_obj_req_s obj;
    int mismatches = 0, comparisons = 0;
    // Fault codes and alarm words per cause bit, overvoltage first
    logic [15:0] code[6] = '{16'h3110, 16'h2211, 16'h8611, 16'h3151, 16'h3150, 16'h7500};
    logic [15:0] alm[6] = '{16'h0004, 16'h0002, 16'h0080, 16'h0001, 16'h0001, 16'h0000};
    sdso_row_s rows[16] = '{
        '{1, 16'h200d, 16'h1, 0, 0}, '{0, 16'h200d, 0, 16'h1, 0}, '{1, 16'h200d, 16'h2, 0, 1},
        '{1, 16'h200e, 0, 0, 1}, '{0, 16'h200f, 0, 16'h0021, 0},
        '{1, 16'h2011, 16'h2, 0, 0}, '{0, 16'h2011, 0, 0, 0},
        '{0, 16'h2022, 0, 0, 0}, '{1, 16'h2022, 16'h1, 0, 1},
        '{0, 16'h2043, 0, 16'h0bb8, 0}, '{0, 16'h2044, 0, 16'h0bb8, 0},
        '{0, 16'h2048, 0, 16'h1234, 0}, '{0, 16'h2049, 0, 16'h002a, 0}, '{0, 16'h204a, 0, 16'h0002, 0},
        '{1, 16'h2060, 16'h03e8, 0, 0}, '{1, 16'h2061, 16'h0401, 0, 1}};
    always #5 clk = ~clk;
    sdso_master_model mm_u (.i_clk_sys(clk), .i_ack(ack), .i_abort(ab), .i_rdata(rd), .o_obj(obj));
    sdso_object_bank #(.POS_WIDTH(4)) dut_u (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(en), .i_obj(obj),
        .o_obj_ack(ack), .o_obj_abort(ab), .o_obj_rdata(rd), .i_fault(flt), .i_drive(drv),
        .i_step_pulse(step), .i_cmd_dir(dir), .i_speed_cmd(spd), .i_bus_voltage(vb),
        .i_input_lines(pins), .i_output_active(oact), .o_motor_dir(mdir), .o_loop_mode(mode),
        .o_harmonic_amp(amp), .o_harmonic_phase_a(pa), .o_harmonic_phase_b(pb), .o_position_actual(pos),
        .o_fault_active(fa));
    // Variant with the closed loop fitted; only its mode output is watched
    sdso_object_bank #(.OPEN_LOOP_ONLY(1'b0)) dut_cl_u (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(en),
        .i_obj(obj), .o_obj_ack(), .o_obj_abort(), .o_obj_rdata(), .i_fault(flt), .i_drive(drv),
        .i_step_pulse(step), .i_cmd_dir(dir), .i_speed_cmd(spd), .i_bus_voltage(vb), .i_input_lines(pins),
        .i_output_active(oact), .o_motor_dir(), .o_loop_mode(mode_cl), .o_harmonic_amp(), .o_harmonic_phase_a(),
        .o_harmonic_phase_b(), .o_position_actual(), .o_fault_active());
    // Access and compare; read data is only meaningful when not refused
    task acc(input logic w, input logic [15:0] i, input logic [15:0] d, input logic [15:0] r, input logic a);
        logic [15:0] q;
        logic b;
        mm_u.access(w, i, d, q, b);
        `CHK(b, a)
        if (a === 1'b0) `CHK(q, r)
    endtask
    // Step pulses with a quiet cycle between them
    task pulses(input int n, input logic up);
        repeat (n) begin
            @(negedge clk);
            step = 1;
            dir = up;
            @(negedge clk);
            step = 0;
        end
    endtask
    task complete_run;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #300000;
        mismatches++;
        complete_run;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        acc(0, 16'h200d, 0, 0, 0);
        acc(0, 16'h2000, 0, 0, 1);
        foreach (rows[k]) acc(rows[k].w, rows[k].i, rows[k].d, rows[k].r, rows[k].a);
        acc(1, 16'h2060, 16'h03e9, 0, 1);
        `CHK(mode_cl, SDSO_FIELD_ORIENTED_CONTROL)
        acc(1, 16'h2011, 16'h1, 0, 0);
        `CHK(mode_cl, SDSO_CLOSED_LOOP)
        spd = -16'sd4000;
        acc(0, 16'h2044, 0, 16'hf448, 0);
        `CHK(mode, SDSO_OPEN_LOOP)
        `CHK({amp, pa, pb}, 48'h03e8_0000_0000)
        `CHK(mdir, 1'b0)
        pulses(10, 1);
        @(negedge clk);
        `CHK(pos, 4'sd7)
        pulses(20, 0);
        @(negedge clk);
        `CHK(pos, -4'sd8)
        en = 0;
        pulses(3, 1);
        en = 1;
        `CHK(pos, -4'sd8)
        acc(1, 16'h2010, 16'h1, 0, 0);
        `CHK(pos, 4'sd0)
        for (int k = 0; k < 6; k++) begin
            flt = sdso_fault_s'(6'(1 << k));
            repeat (2) @(negedge clk);
            acc(1, 16'h6040, 16'h0080, 0, 0);
            acc(0, 16'h603f, 0, code[k], 0);
            acc(0, 16'h200e, 0, alm[k], 0);
            acc(0, 16'h200f, 0, 16'h0023, 0);
            `CHK(fa, 1'b1)
            flt = '0;
            acc(1, 16'h6040, 16'h0080, 0, 0);
            acc(0, 16'h603f, 0, 0, 0);
            acc(0, 16'h200e, 0, 0, 0);
        end
        // Reset in mid-run: settings drop to their reset values at once
        rst_n = 0;
        @(negedge clk);
        `CHK({mdir, amp}, 17'h0)
        rst_n = 1;
        repeat (3) @(negedge clk);
        acc(0, 16'h200d, 0, 0, 0);
        `CHK(mdir, 1'b1)
        complete_run;
    end
endmodule

// File: hdl/sdso_object_bank.sv
// Drive status object bank: settings, alarm and fault reporting,
// position zeroing, readouts of speed, voltage and pin levels.
// Assumes the fieldbus slave stack and motion logic share i_clk_sys;
// only the input pins and the reset arrive from outside and are synchronised here.
// Operation
// - Invert object reverses motor rotation sense
// - Alarm word bits: voltage, current, overvoltage, tracking
// - Fault reset clears alarm word and fault code when no cause is present
// - Status word: enabled, failed, position, running, homed, ready
// - Writing one to zeroing object clears position
// - Position counter saturates instead of wrapping
// - Mode object: open, closed, field oriented
// - Open-loop-only variant ignores nonzero mode writes
// - Commanded speed readout limited to plus/minus 3000
// - Speed feedback returns estimated speed reference
// - Bus voltage reported in ten millivolt units
// - Six raw input levels in bits zero-five
// - Two output levels, zero meaning active
// - Harmonic amplitude setting, range 0 to 1000
// - A winding harmonic phase, range 0 to 1024
// - B winding harmonic phase, fixed by parameter, read only
// - Profile fault code loaded per fault cause
// - Actual position is signed step count, POS_WIDTH bits wide (32 by default)
`timescale 1ns/1ps
module sdso_object_bank #(
    parameter bit OPEN_LOOP_ONLY = 1'b1, // Variant without closed loop
    parameter logic [15:0] PHASE_B_SETTING = 16'h0000, // Fixed B phase
    parameter int POS_WIDTH = 32 // Width of the position count
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire sdso_pkg::sdso_obj_req_s i_obj,
    output logic o_obj_ack,
    output logic o_obj_abort,
    output logic [15:0] o_obj_rdata,
    input wire sdso_pkg::sdso_fault_s i_fault,
    input wire sdso_pkg::sdso_drive_s i_drive,
    input wire logic i_step_pulse,
    input wire logic i_cmd_dir,
    input wire logic signed [15:0] i_speed_cmd,
    input wire logic [15:0] i_bus_voltage,
    input wire logic [sdso_pkg::N_INPUT_LINES-1:0] i_input_lines,
    input wire logic [sdso_pkg::N_OUTPUT_LINES-1:0] i_output_active,
    output logic o_motor_dir,
    output sdso_pkg::sdso_loop_mode_e o_loop_mode,
    output logic [15:0] o_harmonic_amp,
    output logic [15:0] o_harmonic_phase_a,
    output logic [15:0] o_harmonic_phase_b,
    output logic signed [POS_WIDTH-1:0] o_position_actual,
    output logic o_fault_active
);
    import sdso_pkg::*;

    // Limits a signed speed to the reportable range
    function automatic logic [15:0] clamp_speed(input logic signed [15:0] v);
        if (v > SPEED_LIMIT) begin
            clamp_speed = SPEED_LIMIT;
        end else if (v < -SPEED_LIMIT) begin
            clamp_speed = -SPEED_LIMIT;
        end else begin
            clamp_speed = v;
        end
    endfunction

    // Profile fault code for the most urgent cause present
    function automatic logic [15:0] fault_to_code(input sdso_fault_s f);
        if (f.overcurrent) begin
            fault_to_code = FC_OVERCURRENT;
        end else if (f.overvoltage) begin
            fault_to_code = FC_OVERVOLTAGE;
        end else if (f.volt_a) begin
            fault_to_code = FC_VOLT_A;
        end else if (f.volt_b) begin
            fault_to_code = FC_VOLT_B;
        end else if (f.tracking) begin
            fault_to_code = FC_TRACKING;
        end else if (f.comm_fail) begin
            fault_to_code = FC_COMM_FAIL;
        end else begin
            fault_to_code = RST_OBJECT;
        end
    endfunction

    // Reset synchroniser, runs even with the clock enable low so reset always releases
    logic rst_meta; // First stage, read only by rst_sync
    logic rst_sync; // Reset used by the rest of the bank
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Input pin synchroniser; pins are asynchronous to the control clock
    logic [N_INPUT_LINES-1:0] in_meta; // First stage
    logic [N_INPUT_LINES-1:0] in_sync; // Safe copy of the pins
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            in_meta <= '0;
            in_sync <= '0;
        end else if (i_clk_en) begin
            in_meta <= i_input_lines;
            in_sync <= in_meta;
        end
    end

    // Settings and reported words
    logic [15:0] direction_invert; // Rotation sense inversion
    logic [15:0] alarm_word; // Sticky alarm bits
    logic [15:0] drive_status_word; // Condition bits
    logic [15:0] position_zeroing; // Last zeroing value written
    logic [15:0] loop_mode_select; // Control loop selection
    logic [15:0] speed_command_readout; // Clamped commanded speed
    logic [15:0] speed_estimate_readout; // Estimated speed
    logic [15:0] supply_voltage_readout; // Bus voltage in 10 mV
    logic [15:0] input_pin_levels; // Raw input levels
    logic [15:0] output_pin_levels; // Output levels, low is active
    logic [15:0] resonance_harmonic_amplitude; // Anti-resonance amplitude
    logic [15:0] resonance_phase_a; // A winding harmonic phase
    logic [15:0] profile_fault_code; // Profile fault code
    logic [15:0] control_word; // Last control word written
    logic motor_dir; // Registered rotation sense
    logic ack; // Access answered
    logic abort; // Access refused
    logic [15:0] rdata; // Read data register

    // Access decode
    wire is_wr = i_obj.req && i_obj.we;
    wire is_reserved = (i_obj.index >= IDX_RESERVED_LO) && (i_obj.index <= IDX_RESERVED_HI);
    wire hit_dir = (i_obj.index == IDX_DIRECTION_INVERT);
    wire hit_zero = (i_obj.index == IDX_POSITION_ZEROING);
    wire hit_mode = (i_obj.index == IDX_LOOP_MODE_SELECT);
    wire hit_amp = (i_obj.index == IDX_HARMONIC_AMPLITUDE);
    wire hit_pha = (i_obj.index == IDX_RESONANCE_PHASE_A);
    wire hit_fault = (i_obj.index == IDX_PROFILE_FAULT_CODE);
    wire hit_ctrl = (i_obj.index == IDX_CONTROL_WORD);
    // Value range check on the five settings; out-of-range writes are refused
    wire wr_dir = is_wr && hit_dir && (i_obj.wdata <= DIR_MAX);
    wire wr_zero = is_wr && hit_zero && (i_obj.wdata <= ZERO_MAX);
    wire wr_mode = is_wr && hit_mode && (i_obj.wdata <= MODE_MAX);
    wire wr_amp = is_wr && hit_amp && (i_obj.wdata <= AMP_MAX);
    wire wr_pha = is_wr && hit_pha && (i_obj.wdata <= PHASE_MAX);
    wire wr_fault = is_wr && hit_fault;
    wire wr_ctrl = is_wr && hit_ctrl;
    wire wr_ok = wr_dir || wr_zero || wr_mode || wr_amp || wr_pha || wr_fault || wr_ctrl;
    // Open-loop-only variant keeps open loop whatever is written
    wire [15:0] mode_stored = OPEN_LOOP_ONLY ? RST_OBJECT : i_obj.wdata;

    // Fault handling
    wire [15:0] alarm_now = (16'h0001 << ALM_INT_VOLT_BIT) & {16{i_fault.volt_a | i_fault.volt_b}}
        | (16'h0001 << ALM_OVERCURRENT_BIT) & {16{i_fault.overcurrent}}
        | (16'h0001 << ALM_OVERVOLT_BIT) & {16{i_fault.overvoltage}}
        | (16'h0001 << ALM_POS_ERROR_BIT) & {16{i_fault.tracking}};
    wire cause_any = |i_fault;
    wire fault_reset = wr_ctrl && i_obj.wdata[CW_FAULT_RESET_BIT];
    // Reset only takes effect once every cause has gone
    wire clear_ok = fault_reset && !cause_any;
    wire [15:0] code_now = fault_to_code(i_fault);
    // New cause wins over clear and over a master write
    wire [15:0] next_fault_code = cause_any ? code_now :
        clear_ok ? RST_OBJECT :
        wr_fault ? i_obj.wdata : profile_fault_code;
    wire [15:0] next_alarm = (clear_ok ? RST_OBJECT : alarm_word) | alarm_now;
    wire failed = (alarm_word != RST_OBJECT) || (profile_fault_code != RST_OBJECT);
    wire [15:0] next_status = (16'(i_drive.enabled) << STS_ENABLED_BIT)
        | (16'(failed) << STS_FAILED_BIT)
        | (16'(i_drive.in_position) << STS_IN_POSITION_BIT)
        | (16'(i_drive.running) << STS_RUNNING_BIT)
        | (16'(i_drive.homing_done) << STS_HOMED_BIT)
        | (16'(i_drive.ready) << STS_READY_BIT);

    // Read selection; reserved indices read as zero
    logic [15:0] rd_value;
    logic rd_known;
    always_comb begin
        rd_value = RST_OBJECT;
        rd_known = 1'b1;
        case (i_obj.index)
            IDX_DIRECTION_INVERT: rd_value = direction_invert;
            IDX_ALARM_WORD: rd_value = alarm_word;
            IDX_DRIVE_STATUS_WORD: rd_value = drive_status_word;
            IDX_POSITION_ZEROING: rd_value = position_zeroing;
            IDX_LOOP_MODE_SELECT: rd_value = loop_mode_select;
            IDX_SPEED_COMMAND: rd_value = speed_command_readout;
            IDX_SPEED_ESTIMATE: rd_value = speed_estimate_readout;
            IDX_SUPPLY_VOLTAGE: rd_value = supply_voltage_readout;
            IDX_INPUT_PIN_LEVELS: rd_value = input_pin_levels;
            IDX_OUTPUT_PIN_LEVELS: rd_value = output_pin_levels;
            IDX_HARMONIC_AMPLITUDE: rd_value = resonance_harmonic_amplitude;
            IDX_RESONANCE_PHASE_A: rd_value = resonance_phase_a;
            IDX_RESONANCE_PHASE_B: rd_value = PHASE_B_SETTING;
            IDX_PROFILE_FAULT_CODE: rd_value = profile_fault_code;
            IDX_CONTROL_WORD: rd_value = control_word;
            default: rd_known = is_reserved;
        endcase
    end
    // Reserved writes and read-only or out-of-range writes are refused
    wire refuse = i_obj.req && (i_obj.we ? (is_reserved || !wr_ok) : !rd_known);

    // Settings written by the master
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            direction_invert <= RST_OBJECT;
            position_zeroing <= RST_OBJECT;
            loop_mode_select <= RST_OBJECT;
            resonance_harmonic_amplitude <= RST_OBJECT;
            resonance_phase_a <= RST_OBJECT;
            control_word <= RST_OBJECT;
        end else if (i_clk_en) begin
            if (wr_dir) begin
                direction_invert <= i_obj.wdata;
            end
            if (wr_zero) begin
                position_zeroing <= i_obj.wdata;
            end
            if (wr_mode) begin
                loop_mode_select <= mode_stored;
            end
            if (wr_amp) begin
                resonance_harmonic_amplitude <= i_obj.wdata;
            end
            if (wr_pha) begin
                resonance_phase_a <= i_obj.wdata;
            end
            if (wr_ctrl) begin
                control_word <= i_obj.wdata;
            end
        end
    end

    // Reported words refresh on every control cycle with the clock enable high
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            alarm_word <= RST_OBJECT;
            profile_fault_code <= RST_OBJECT;
            drive_status_word <= RST_OBJECT;
            speed_command_readout <= RST_OBJECT;
            speed_estimate_readout <= RST_OBJECT;
            supply_voltage_readout <= RST_OBJECT;
            input_pin_levels <= RST_OBJECT;
            output_pin_levels <= RST_OBJECT;
        end else if (i_clk_en) begin
            alarm_word <= next_alarm;
            profile_fault_code <= next_fault_code;
            drive_status_word <= next_status;
            speed_command_readout <= clamp_speed(i_speed_cmd);
            // No encoder, so feedback is the estimate taken from the reference
            speed_estimate_readout <= clamp_speed(i_speed_cmd);
            supply_voltage_readout <= i_bus_voltage;
            input_pin_levels <= {{(16-N_INPUT_LINES){1'b0}}, in_sync};
            output_pin_levels <= {{(16-N_OUTPUT_LINES){1'b0}}, ~i_output_active};
        end
    end

    // Rotation sense and access answer
    always_ff @(posedge i_clk_sys or negedge rst_sync) begin
        if (!rst_sync) begin
            motor_dir <= 1'b0;
            ack <= 1'b0;
            abort <= 1'b0;
            rdata <= RST_OBJECT;
        end else if (i_clk_en) begin
            motor_dir <= i_cmd_dir ^ direction_invert[0];
            ack <= i_obj.req;
            abort <= refuse;
            rdata <= (i_obj.req && !i_obj.we) ? rd_value : RST_OBJECT;
        end
    end

    // Position counter; count up follows the commanded sense
    sdso_pos_counter #(
        .WIDTH(POS_WIDTH)
    ) u_pos_counter (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_sync),
        .i_clk_en(i_clk_en),
        .i_step(i_step_pulse),
        .i_up(i_cmd_dir),
        .i_clear(wr_zero && (i_obj.wdata == ZERO_CMD)),
        .o_count(o_position_actual)
    );

    assign o_obj_ack = ack;
    assign o_obj_abort = abort;
    assign o_obj_rdata = rdata;
    assign o_motor_dir = motor_dir;
    assign o_loop_mode = (loop_mode_select == 16'h0001) ? SDSO_CLOSED_LOOP :
        (loop_mode_select == MODE_MAX) ? SDSO_FIELD_ORIENTED_CONTROL : SDSO_OPEN_LOOP;
    assign o_harmonic_amp = resonance_harmonic_amplitude;
    assign o_harmonic_phase_a = resonance_phase_a;
    assign o_harmonic_phase_b = PHASE_B_SETTING;
    assign o_fault_active = drive_status_word[STS_FAILED_BIT];

    default clocking cb_sys @(posedge i_clk_sys); endclocking
    default disable iff (!rst_sync);

    dir_invert_a: assert property (i_clk_en && direction_invert == 16'h0001 |=> o_motor_dir != $past(i_cmd_dir))
        else $error("motor sense not inverted");
    alarm_set_a: assert property (i_clk_en && i_fault.overcurrent |=> alarm_word[ALM_OVERCURRENT_BIT])
        else $error("overcurrent alarm bit missing");
    fault_clear_a: assert property (i_clk_en && clear_ok |=> alarm_word == 0 && profile_fault_code == 0)
        else $error("fault reset did not clear alarm and code");
    status_run_a: assert property (i_clk_en && i_drive.running |=> drive_status_word[STS_RUNNING_BIT])
        else $error("running bit missing");
    zero_pos_a: assert property (i_clk_en && wr_zero && i_obj.wdata == ZERO_CMD |=> o_position_actual == 0)
        else $error("position not zeroed");
    open_only_a: assert property (OPEN_LOOP_ONLY |-> o_loop_mode == SDSO_OPEN_LOOP)
        else $error("open-loop-only variant left open loop");
    speed_limit_a: assert property (i_clk_en && i_speed_cmd > SPEED_LIMIT |=> speed_command_readout == 16'h0bb8)
        else $error("speed readout not limited");
    fault_hold_a: assert property (i_clk_en && fault_reset && i_fault.overvoltage |=> alarm_word[ALM_OVERVOLT_BIT]
        && profile_fault_code != 0)
        else $error("fault cleared while cause persists");
    comm_code_a: assert property (i_clk_en && i_fault == 6'b100000 |=> profile_fault_code == FC_COMM_FAIL)
        else $error("communication fault code wrong");
    out_level_a: assert property (i_clk_en && i_output_active[0] |=> !output_pin_levels[0] ##0
        output_pin_levels[15:N_OUTPUT_LINES] == 0)
        else $error("output level polarity wrong");
    access_ack_a: assert property (i_clk_en && i_obj.req |=> o_obj_ack)
        else $error("access not answered");
    // Out-of-range settings must be refused and leave the stored value alone
    amp_range_a: assert property (i_clk_en && is_wr && hit_amp && i_obj.wdata > AMP_MAX |=> o_obj_abort)
        else $error("amplitude out of range accepted");
    phase_keep_a: assert property (i_clk_en && is_wr && hit_pha && !wr_pha |=>
        $stable(resonance_phase_a))
        else $error("refused phase write changed the setting");
    // Readouts are registered, voltage a plain copy, speed limited; upper bits of the pin word stay clear
    in_upper_a: assert property (i_clk_en |=> input_pin_levels[15:N_INPUT_LINES] == 0)
        else $error("unused input level bits set");
    volt_copy_a: assert property (i_clk_en |=> supply_voltage_readout == $past(i_bus_voltage))
        else $error("bus voltage readout not a copy");
    speed_neg_a: assert property (i_clk_en && i_speed_cmd < -SPEED_LIMIT |=>
        speed_estimate_readout == 16'hf448)
        else $error("negative speed estimate not limited");

    fault_cycle_c: cover property (i_clk_en && cause_any ##[1:20] i_clk_en && clear_ok);
    zero_write_c: cover property (i_clk_en && wr_zero && i_obj.wdata == ZERO_CMD);
    reserved_wr_c: cover property (i_clk_en && is_wr && is_reserved);
    mode_foc_c: cover property (i_clk_en && wr_mode && i_obj.wdata == MODE_MAX);
    refused_c: cover property (o_obj_ack && o_obj_abort);
endmodule

// File: hdl/sdso_pkg.sv
// Package for the drive status object bank: object indices, field positions,
// reset values, limits, fault codes, mode enumeration and carrier structs.
// Assumes every file of the bank imports it whole.
package sdso_pkg;

    // Object indices of the bank
    localparam logic [15:0] IDX_DIRECTION_INVERT = 16'h200d;
    localparam logic [15:0] IDX_ALARM_WORD = 16'h200e;
    localparam logic [15:0] IDX_DRIVE_STATUS_WORD = 16'h200f;
    localparam logic [15:0] IDX_POSITION_ZEROING = 16'h2010;
    localparam logic [15:0] IDX_LOOP_MODE_SELECT = 16'h2011;
    localparam logic [15:0] IDX_RESERVED_LO = 16'h2020;
    localparam logic [15:0] IDX_RESERVED_HI = 16'h2026;
    localparam logic [15:0] IDX_SPEED_COMMAND = 16'h2043;
    localparam logic [15:0] IDX_SPEED_ESTIMATE = 16'h2044;
    localparam logic [15:0] IDX_SUPPLY_VOLTAGE = 16'h2048;
    localparam logic [15:0] IDX_INPUT_PIN_LEVELS = 16'h2049;
    localparam logic [15:0] IDX_OUTPUT_PIN_LEVELS = 16'h204a;
    localparam logic [15:0] IDX_HARMONIC_AMPLITUDE = 16'h2060;
    localparam logic [15:0] IDX_RESONANCE_PHASE_A = 16'h2061;
    localparam logic [15:0] IDX_RESONANCE_PHASE_B = 16'h2062;
    localparam logic [15:0] IDX_PROFILE_FAULT_CODE = 16'h603f;
    localparam logic [15:0] IDX_CONTROL_WORD = 16'h6040;

    // Values after reset
    localparam logic [15:0] RST_OBJECT = 16'h0000;
    localparam logic [31:0] RST_POSITION = 32'h0000_0000;

    // Alarm word bit positions
    localparam int ALM_INT_VOLT_BIT = 0;
    localparam int ALM_OVERCURRENT_BIT = 1;
    localparam int ALM_OVERVOLT_BIT = 2;
    localparam int ALM_POS_ERROR_BIT = 7;

    // Status word bit positions
    localparam int STS_ENABLED_BIT = 0;
    localparam int STS_FAILED_BIT = 1;
    localparam int STS_IN_POSITION_BIT = 2;
    localparam int STS_RUNNING_BIT = 3;
    localparam int STS_HOMED_BIT = 4;
    localparam int STS_READY_BIT = 5;

    // Control word fault reset bit
    localparam int CW_FAULT_RESET_BIT = 7;

    // Profile fault codes
    localparam logic [15:0] FC_COMM_FAIL = 16'h7500;
    localparam logic [15:0] FC_VOLT_A = 16'h3150;
    localparam logic [15:0] FC_VOLT_B = 16'h3151;
    localparam logic [15:0] FC_TRACKING = 16'h8611;
    localparam logic [15:0] FC_OVERCURRENT = 16'h2211;
    localparam logic [15:0] FC_OVERVOLTAGE = 16'h3110;

    // Value ranges of the writable objects and readouts
    localparam logic [15:0] DIR_MAX = 16'h0001;
    localparam logic [15:0] ZERO_CMD = 16'h0001;
    localparam logic [15:0] ZERO_MAX = 16'h0001;
    localparam logic [15:0] MODE_MAX = 16'h0002;
    localparam logic [15:0] AMP_MAX = 16'h03e8;
    localparam logic [15:0] PHASE_MAX = 16'h0400;
    localparam logic signed [15:0] SPEED_LIMIT = 16'sh0bb8;

    // Number of input and output lines
    localparam int N_INPUT_LINES = 6;
    localparam int N_OUTPUT_LINES = 2;

    // Motor control loop selection
    typedef enum logic [1:0] {
        SDSO_OPEN_LOOP,
        SDSO_CLOSED_LOOP,
        SDSO_FIELD_ORIENTED_CONTROL
    } sdso_loop_mode_e;

    // Fault causes, present while the condition persists
    typedef struct packed {
        logic comm_fail;
        logic volt_a;
        logic volt_b;
        logic tracking;
        logic overcurrent;
        logic overvoltage;
    } sdso_fault_s;

    // Drive conditions reported by the motion logic
    typedef struct packed {
        logic enabled;
        logic in_position;
        logic running;
        logic homing_done;
        logic ready;
    } sdso_drive_s;

    // One object access from the fieldbus slave stack
    typedef struct packed {
        logic req;
        logic we;
        logic [15:0] index;
        logic [15:0] wdata;
    } sdso_obj_req_s;

endpackage

// File: hdl/sdso_pos_counter.sv
// Saturating signed step counter holding the actual position.
// Assumes step and direction come from logic on the same clock.
`timescale 1ns/1ps
module sdso_pos_counter #(
    parameter int WIDTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_step,
    input wire logic i_up,
    input wire logic i_clear,
    output logic signed [WIDTH-1:0] o_count
);
    import sdso_pkg::*;

    // Saturation limits of a signed count
    localparam logic signed [WIDTH-1:0] CNT_MAX = {1'b0, {(WIDTH-1){1'b1}}};
    localparam logic signed [WIDTH-1:0] CNT_MIN = {1'b1, {(WIDTH-1){1'b0}}};

    logic signed [WIDTH-1:0] count; // Position in step pulses
    logic signed [WIDTH-1:0] next_count; // Value for the next edge
    logic at_max; // Counter pinned high
    logic at_min; // Counter pinned low

    assign at_max = (count == CNT_MAX);
    assign at_min = (count == CNT_MIN);
    // Clear beats stepping; a long one-way move pins instead of wrapping
    assign next_count = i_clear ? RST_POSITION[WIDTH-1:0] :
        (!i_step) ? count :
        (i_up && !at_max) ? count + 1'b1 :
        (!i_up && !at_min) ? count - 1'b1 :
        count;

    // Counter register, frozen while the clock enable is low
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= RST_POSITION[WIDTH-1:0];
        end else if (i_clk_en) begin
            count <= next_count;
        end
    end

    assign o_count = count;

    default clocking cb_cnt @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    count_sat_a: assert property (i_clk_en && at_max && i_step && i_up && !i_clear |=> at_max)
        else $error("position counter wrapped past its upper limit");
    count_clear_a: assert property (i_clk_en && i_clear |=> count == 0 [*1] ##1 (count == 0 || $past(i_step)))
        else $error("position counter not zero after clear");
endmodule
